/* File: common/pom_pkg.sv */
// Purpose: Shared constants and types of the PTC overheat monitor
// Assumes: 50 MHz system clock, sense samples in 0.01 V steps
// Notes: Thresholds are in 0.1 V steps, smoothing time in 0.01 s steps
`default_nettype none

package pom_pkg;
	// ==========================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_TIME_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_TIME_MS;
	localparam int SEC_TICKS = 1000 / TICK_TIME_MS;
	localparam int TCNT_W = 20;

	// ==========================================
	// Widths and ranges
	localparam int SAMPLE_W = 10;
	localparam int THR_W = 7;
	localparam int TAU_W = 10;
	localparam int DLY_W = 9;
	localparam int CNT_W = 16;
	localparam int FRAC_W = 8;
	localparam int ACC_W = SAMPLE_W + FRAC_W;
	localparam int DIV_STEPS = ACC_W;
	localparam int THR_SCALE = 10;
	localparam logic [TAU_W-1:0] TAU_MAX = 10'h3E8;
	localparam logic [DLY_W-1:0] DELAY_MIN_S = 9'h001;
	localparam logic [DLY_W-1:0] DELAY_MAX_S = 9'h12C;

	// ==========================================
	// Reset values
	localparam logic [ACC_W-1:0] FILT_RST = 18'h00000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

	// ==========================================
	// Modes and states
	typedef enum logic [1:0] {
		POM_MODE_OFF,
		POM_MODE_DECEL,
		POM_MODE_COAST,
		POM_MODE_WARN
	} pom_mode_e;

	typedef enum logic {
		POM_ST_WATCH,
		POM_ST_FAULT
	} pom_state_e;
endpackage

`default_nettype wire

/* File: common/pom_if.sv */
// Purpose: Link between the monitor and its smoothing filter
// Assumes: One clock domain
// Notes: tick starts one filter step, filt_upd marks its result
`default_nettype none

interface pom_if;
	logic tick;
	logic [pom_pkg::SAMPLE_W-1:0] sample;
	logic [pom_pkg::TAU_W-1:0] tau;
	logic [pom_pkg::SAMPLE_W-1:0] filt;
	logic filt_upd;

	modport ctl(output tick, output sample, output tau, input filt, input filt_upd);
	modport flt(input tick, input sample, input tau, output filt, output filt_upd);
endinterface

`default_nettype wire

/* File: rtl/pom_filter.sv */
// Purpose: First-order smoothing of the sensed voltage
// Assumes: Ticks spaced more than DIV_STEPS + 1 cycles apart
// Notes: Each step adds (x - y) / (tau + 1) by serial division
`default_nettype none

module pom_filter (
	input wire logic clk,
	input wire logic sys_rst,
	pom_if.flt f
);
	import pom_pkg::*;

	typedef struct packed {
		logic busy;
		logic [4:0] cnt;
		logic neg;
		logic [TAU_W:0] div;
		logic [TAU_W:0] rem;
		logic [ACC_W-1:0] quot;
		logic [ACC_W-1:0] y;
		logic upd;
	} pom_flt_s;

	pom_flt_s s_q, s_d;
	logic [TAU_W+1:0] trial;
	logic [ACC_W-1:0] xs;

	// ==========================================
	// Step start and restoring division
	always_comb begin
		s_d = s_q;
		s_d.upd = 1'b0;
		xs = {f.sample, 8'h00};
		trial = 12'h000;
		if (!s_q.busy) begin
			if (f.tick) begin
				s_d.busy = 1'b1;
				s_d.cnt = 5'h00;
				s_d.rem = 11'h000;
				s_d.div = 11'(f.tau) + 11'h001;
				s_d.neg = xs < s_q.y;
				s_d.quot = (xs < s_q.y) ? (s_q.y - xs) : (xs - s_q.y);
			end
		end else begin
			trial = {s_q.rem, s_q.quot[ACC_W-1]};
			s_d.quot = {s_q.quot[ACC_W-2:0], 1'b0};
			if (trial >= {1'b0, s_q.div}) begin
				trial = trial - {1'b0, s_q.div};
				s_d.quot[0] = 1'b1;
			end
			s_d.rem = trial[TAU_W:0];
			s_d.cnt = s_q.cnt + 5'h01;
			// Last step moves the output toward the sample
			if (s_q.cnt == 5'(DIV_STEPS - 1)) begin
				s_d.busy = 1'b0;
				s_d.upd = 1'b1;
				s_d.y = s_q.neg ? (s_q.y - s_d.quot) : (s_q.y + s_d.quot);
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.y <= FILT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign f.filt = s_q.y[ACC_W-1:FRAC_W];
	assign f.filt_upd = s_q.upd;

	// With no smoothing the output equals the sample after one step
	filt_passthru_a: assert property (@(posedge clk) disable iff (sys_rst)
		(f.tick && !s_q.busy && f.tau == 10'h000)
		|-> ##19 (f.filt_upd && f.filt == $past(f.sample, 19)))
		else $error("filter output does not follow sample with zero smoothing");
endmodule

`default_nettype wire

/* File: rtl/pom_monitor.sv */
// Purpose: PTC motor overheat monitor, top level
// Assumes: Settings held steady by software, samples in 0.01 V steps
// Notes: Detection runs once per filter step, every 10 ms
//
// Summary of operation
// - Mode 0 disables protection, 1 decelerates, 2 coasts, 3 warns then coasts at protection level.
// - The sensed voltage is smoothed with a time constant of 0 to 10.00 s before any compare.
// - An over-threshold condition must persist for the 1 to 300 s detection delay to fault.
// - In modes 1 and 2 exceeding the warning level for the delay sets the fault and the stop.
// - In mode 3 exceeding the warning level raises the warning flag while the motor runs.
// - In mode 3 exceeding the protection level for the delay sets the fault and a coast stop.
// - The fault clears only while the smoothed voltage is below the reset level.
`default_nettype none

module pom_monitor #(
	parameter int TICK_CYCLES = pom_pkg::TICK_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic analog_sense_valid,
	input wire logic [pom_pkg::SAMPLE_W-1:0] analog_sense_input,
	input wire pom_pkg::pom_mode_e resp_mode,
	input wire logic [pom_pkg::TAU_W-1:0] smooth_time,
	input wire logic [pom_pkg::DLY_W-1:0] detect_delay,
	input wire logic [pom_pkg::THR_W-1:0] protect_level,
	input wire logic [pom_pkg::THR_W-1:0] reset_level,
	input wire logic [pom_pkg::THR_W-1:0] warn_level,
	input wire logic fault_clear,
	output logic overheat_warning_flag,
	output logic overheat_fault_flag,
	output logic decel_stop_req,
	output logic coast_stop_req,
	output logic [pom_pkg::SAMPLE_W-1:0] filtered_level
);
	import pom_pkg::*;

	typedef struct packed {
		logic [TCNT_W-1:0] tcnt;
		logic tick;
		logic [SAMPLE_W-1:0] smp;
		logic [CNT_W-1:0] cnt;
		pom_state_e state;
		logic warn;
		logic fault;
		logic decel;
		logic coast;
		logic [SAMPLE_W-1:0] filt;
	} pom_mon_s;

	pom_mon_s s_q, s_d;
	pom_if u_if();
	logic [TAU_W-1:0] tau_c;
	logic [DLY_W-1:0] dly_c;
	logic [CNT_W-1:0] lim;
	logic [THR_W-1:0] thr_act;
	logic [SAMPLE_W:0] filt_x;
	logic exceed;
	logic over_warn;
	logic below_rst;

	// ==========================================
	// Smoothing filter
	pom_filter u_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.f(u_if.flt)
	);

	assign u_if.tick = s_q.tick;
	assign u_if.sample = s_q.smp;
	assign u_if.tau = tau_c;

	// ==========================================
	// Setting limits and compares
	assign tau_c = (smooth_time > TAU_MAX) ? TAU_MAX : smooth_time;
	assign dly_c = (detect_delay < DELAY_MIN_S) ? DELAY_MIN_S :
		(detect_delay > DELAY_MAX_S) ? DELAY_MAX_S : detect_delay;
	assign lim = 16'(dly_c) * 16'(SEC_TICKS);
	assign thr_act = (resp_mode == POM_MODE_WARN) ? protect_level : warn_level;
	assign filt_x = {1'b0, u_if.filt};
	assign exceed = filt_x > 11'(thr_act) * 11'(THR_SCALE);
	assign over_warn = filt_x > 11'(warn_level) * 11'(THR_SCALE);
	assign below_rst = filt_x < 11'(reset_level) * 11'(THR_SCALE);

	// ==========================================
	// Tick divider, sample capture and detection
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.filt = u_if.filt;
		if (s_q.tcnt == TCNT_W'(TICK_CYCLES - 1)) begin
			s_d.tcnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tcnt = s_q.tcnt + 20'h00001;
		end
		if (analog_sense_valid) begin
			s_d.smp = analog_sense_input;
		end
		// Warning follows the smoothed level in mode 3 only
		s_d.warn = (resp_mode == POM_MODE_WARN) && over_warn;
		unique case (s_q.state)
			POM_ST_WATCH: begin
				if (resp_mode == POM_MODE_OFF) begin
					s_d.cnt = CNT_RST;
				end else if (u_if.filt_upd) begin
					if (!exceed) begin
						s_d.cnt = CNT_RST;
					end else if (s_q.cnt + 16'h0001 >= lim) begin
						s_d.cnt = CNT_RST;
						s_d.state = POM_ST_FAULT;
						s_d.fault = 1'b1;
						s_d.decel = (resp_mode == POM_MODE_DECEL);
						s_d.coast = (resp_mode != POM_MODE_DECEL);
					end else begin
						s_d.cnt = s_q.cnt + 16'h0001;
					end
				end
			end
			POM_ST_FAULT: begin
				// Clear honoured only once the winding has cooled
				if (fault_clear && below_rst) begin
					s_d.state = POM_ST_WATCH;
					s_d.fault = 1'b0;
					s_d.decel = 1'b0;
					s_d.coast = 1'b0;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.cnt <= CNT_RST;
			s_q.state <= POM_ST_WATCH;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign overheat_warning_flag = s_q.warn;
	assign overheat_fault_flag = s_q.fault;
	assign decel_stop_req = s_q.decel;
	assign coast_stop_req = s_q.coast;
	assign filtered_level = s_q.filt;

	// ==========================================
	// Checks
	mode_off_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.state == POM_ST_WATCH && resp_mode == POM_MODE_OFF)
		|=> (!overheat_fault_flag && s_q.cnt == CNT_RST))
		else $error("fault or count moved while protection disabled");

	delay_full_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(overheat_fault_flag) |-> ($past(s_q.cnt) + 16'h0001 == $past(lim)))
		else $error("fault raised before the detection delay ran out");

	decel_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		($rose(overheat_fault_flag) && $past(resp_mode) != POM_MODE_WARN)
		|-> ($past(over_warn) && decel_stop_req == ($past(resp_mode) == POM_MODE_DECEL)
		&& coast_stop_req == ($past(resp_mode) == POM_MODE_COAST)))
		else $error("wrong stop kind or threshold in mode 1 or 2");

	warn_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		(resp_mode == POM_MODE_WARN && over_warn) |=> (overheat_warning_flag
		&& (!$rose(coast_stop_req) || $past(exceed))))
		else $error("warning flag missing or stop raised below protection in mode 3");

	mode3_coast_a: assert property (@(posedge clk) disable iff (sys_rst)
		($rose(overheat_fault_flag) && $past(resp_mode) == POM_MODE_WARN)
		|-> (coast_stop_req && !decel_stop_req
		&& $past(filt_x) > 11'($past(protect_level)) * 11'(THR_SCALE)))
		else $error("mode 3 fault without coast or below protection level");

	clear_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(overheat_fault_flag) |-> $past(fault_clear && below_rst))
		else $error("fault cleared above the reset level");

	fault_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(overheat_fault_flag && !fault_clear) |=> overheat_fault_flag [*2]
		or (overheat_fault_flag ##1 $past(fault_clear)))
		else $error("fault dropped without a clear");

	count_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.state == POM_ST_WATCH && u_if.filt_upd && !exceed) |=> s_q.cnt == CNT_RST)
		else $error("delay count not restarted after drop below threshold");

	// ==========================================
	// Stop kind, warning scope, count housekeeping and filtered level copy
	stop_kind_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.state == POM_ST_FAULT && !(fault_clear && below_rst))
		|=> (overheat_fault_flag && $stable(decel_stop_req) && $stable(coast_stop_req)))
		else $error("fault or stop kind changed without a valid clear");

	warn_mode_only_a: assert property (@(posedge clk) disable iff (sys_rst)
		(resp_mode != POM_MODE_WARN)
		|=> !overheat_warning_flag)
		else $error("warning flag raised outside mode 3");

	count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.state == POM_ST_WATCH && resp_mode != POM_MODE_OFF && u_if.filt_upd
		&& exceed && s_q.cnt + 16'h0001 < lim)
		|=> (s_q.cnt == $past(s_q.cnt) + 16'h0001))
		else $error("delay count did not advance on an exceeding step");

	fault_at_update_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!u_if.filt_upd)
		|=> !$rose(overheat_fault_flag))
		else $error("fault raised without a filter update");

	level_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1
		|=> (filtered_level == $past(u_if.filt)))
		else $error("filtered level does not follow the filter output");

	clear_all_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(overheat_fault_flag)
		|-> (!decel_stop_req && !coast_stop_req && s_q.state == POM_ST_WATCH))
		else $error("stop request left standing after a fault clear");
endmodule

`default_nettype wire

/* File: bench/pom_adc_model.sv */
// Purpose: Converter model feeding sense samples to the monitor
// Assumes: One clock, one conversion every PERIOD cycles
// Notes: Data line toggles to garbage outside the strobe cycle
`default_nettype none

module pom_adc_model #(
	parameter int PERIOD = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [pom_pkg::SAMPLE_W-1:0] level,
	output logic valid,
	output logic [pom_pkg::SAMPLE_W-1:0] data
);
	timeunit 1ns;
	timeprecision 1ns;
	import pom_pkg::*;
	int cnt;

	// ==========================================
	// Conversion pacing; stale data is inverted each cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt <= 0;
			valid <= 1'b0;
			data <= 10'h000;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			valid <= (cnt == PERIOD - 1);
			data <= (cnt == PERIOD - 1) ? level : ~data;
		end
	end
endmodule

`default_nettype wire

/* File: bench/pom_monitor_tb.sv */
// Purpose: Self-checking bench of the overheat monitor
// Assumes: Shortened filter step of 40 cycles, 100 steps per second
// Notes: Sense samples come from the converter model
`default_nettype none

module pom_monitor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pom_pkg::*;
	localparam int TC = 40;
	logic clk, sys_rst, valid, fault_clear, warn_f, fault_f, decel, coast;
	logic [SAMPLE_W-1:0] data, level, filt, s;
	pom_mode_e resp_mode;
	logic [TAU_W-1:0] smooth_time;
	logic [DLY_W-1:0] detect_delay;
	logic [THR_W-1:0] protect_level, reset_level, warn_level;
	logic [9:0] flags;
	int mismatches, compares;

	assign flags = {6'h00, warn_f, fault_f, decel, coast};

	// ==========================================
	// Design and far side
	pom_monitor #(.TICK_CYCLES(TC)) dut (.clk(clk), .sys_rst(sys_rst),
		.analog_sense_valid(valid), .analog_sense_input(data), .resp_mode(resp_mode),
		.smooth_time(smooth_time), .detect_delay(detect_delay),
		.protect_level(protect_level), .reset_level(reset_level), .warn_level(warn_level),
		.fault_clear(fault_clear), .overheat_warning_flag(warn_f),
		.overheat_fault_flag(fault_f), .decel_stop_req(decel), .coast_stop_req(coast),
		.filtered_level(filt));
	pom_adc_model adc (.clk(clk), .sys_rst(sys_rst), .level(level), .valid(valid),
		.data(data));

	// Expected filter step from zero history
	function automatic logic [9:0] filt_step(int x, int tau);
		return 10'((x * 256 / (tau + 1)) >> 8);
	endfunction

	task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_t(int n);
		repeat (n * TC) @(posedge clk);
		#2;
	endtask

	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Watchdog
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		end_of_test();
	end

	// Main sequence
	initial begin
		void'($urandom(30));
		sys_rst = 1'b1;
		fault_clear = 1'b0;
		level = 10'h000;
		resp_mode = POM_MODE_OFF;
		smooth_time = 10'h009;
		detect_delay = 9'h001;
		protect_level = 7'h32;
		reset_level = 7'h0A;
		warn_level = 7'h0A;
		repeat (20) @(posedge clk);
		#2 sys_rst = 1'b0;
		chk("flags", 10'h000, flags);
		s = 10'(150 + $urandom % 874);
		level = s;
		repeat (65) @(posedge clk);
		#2;
		chk("filtered", filt_step(s, 9), filt);
		smooth_time = 10'h000;
		wait_t(2);
		chk("filtered", s, filt);
		wait_t(150);
		chk("flags", 10'h000, flags);
		resp_mode = POM_MODE_DECEL;
		wait_t(60);
		level = 10'h032;
		wait_t(3);
		level = s;
		wait_t(90);
		chk("flags", 10'h000, flags);
		wait_t(20);
		chk("flags", 10'h006, flags);
		fault_clear = 1'b1;
		wait_t(5);
		chk("flags", 10'h006, flags);
		level = 10'h032;
		wait_t(3);
		chk("flags", 10'h000, flags);
		fault_clear = 1'b0;
		s = 10'(150 + $urandom % 874);
		level = s;
		resp_mode = POM_MODE_COAST;
		wait_t(110);
		chk("flags", 10'h005, flags);
		fault_clear = 1'b1;
		level = 10'h032;
		wait_t(3);
		chk("flags", 10'h000, flags);
		fault_clear = 1'b0;
		resp_mode = POM_MODE_WARN;
		level = 10'h0C8;
		wait_t(3);
		chk("flags", 10'h008, flags);
		wait_t(110);
		chk("flags", 10'h008, flags);
		level = 10'h258;
		wait_t(110);
		chk("flags", 10'h00D, flags);
		fault_clear = 1'b1;
		level = 10'h032;
		wait_t(3);
		chk("flags", 10'h000, flags);
		end_of_test();
	end
endmodule

`default_nettype wire
